// >>> hdl/spg_filt_if.sv
// Signals between the GPIO core and its input filter
`timescale 1ns/1ps
interface spg_filt_if;
    logic raw;
    logic enable;
    logic active;
    logic level;
    logic osc_run;
    modport ctl (output raw, output enable, output active,
        input level, input osc_run);
    modport filt (input raw, input enable, input active,
        output level, output osc_run);
endinterface

// >>> hdl/spg_filter.sv
// Debounce filter with gated timing oscillator
`timescale 1ns/1ps
module spg_filter
    import spg_pkg::*;
#(
    parameter int unsigned CYCLES = FILTER_CYCLE_COUNT
)
(
    input wire logic clk,
    input wire logic rst_n,
    spg_filt_if.filt f
);
    localparam int unsigned CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic level_r;
    logic level_nxt;

    always_comb
    begin
        cnt_nxt = '0;
        level_nxt = level_r;
        if (!f.enable || !f.active)
            level_nxt = f.raw;
        else if (f.raw != level_r)
        begin
            if (cnt_r == LAST)
                level_nxt = f.raw;
            else
                cnt_nxt = cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cnt_r <= '0;
            level_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            level_r <= level_nxt;
        end
    end

    assign f.level = level_r;
    // Oscillator runs only while a change is being timed
    assign f.osc_run = f.enable && f.active && (f.raw != level_r);

    a_filter_hold: assert property (@(posedge clk) disable iff (!rst_n)
        f.enable && f.active && f.raw != level_r && cnt_r != LAST
        |=> $stable(level_r))
        else $error("filtered level moved before the interval ended");
    a_filter_bypass: assert property (@(posedge clk) disable iff (!rst_n)
        !f.enable |=> level_r == $past(f.raw))
        else $error("bypassed filter did not follow input");
    a_osc_idle: assert property (@(posedge clk) disable iff (!rst_n)
        !f.osc_run |=> cnt_r == '0)
        else $error("interval count kept while oscillator stopped");
    c_filter_accept: cover property (@(posedge clk) disable iff (!rst_n)
        f.enable && cnt_r == LAST && f.raw != level_r);
endmodule

// >>> hdl/spg_pkg.sv
// Constants shared by the single-pin GPIO block
package spg_pkg;
    localparam int unsigned CLOCK_KHZ = 100_000;
    localparam int unsigned FILTER_TIME_MS = 30;
    localparam int unsigned FILTER_CYCLE_COUNT = FILTER_TIME_MS * CLOCK_KHZ;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_FLAG = 8'h08;
    localparam logic [7:0] OFS_MASK = 8'h0C;
    localparam int CTRL_DIR = 0;
    localparam int CTRL_DRV = 1;
    localparam int CTRL_VAL = 2;
    localparam int CTRL_FEN = 3;
    localparam int FLAG_RISE = 0;
    localparam int FLAG_FALL = 1;
    localparam logic [3:0] CTRL_RESET = 4'h9;
    localparam logic [1:0] FLAG_RESET = 2'h0;
    localparam logic [1:0] MASK_RESET = 2'h3;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// >>> hdl/spg_sync.sv
// Three-stage pin synchroniser with agreement check
`timescale 1ns/1ps
module spg_sync
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);
    logic [2:0] s_r;
    logic [2:0] s_nxt;
    logic q_r;
    logic q_nxt;

    always_comb
    begin
        s_nxt = {s_r[1:0], d};
        // Only a level seen by both later stages counts
        q_nxt = (s_r[1] == s_r[2]) ? s_r[2] : q_r;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s_r <= 3'h0;
            q_r <= 1'b0;
        end
        else
        begin
            s_r <= s_nxt;
            q_r <= q_nxt;
        end
    end

    assign q = q_r;
endmodule

// >>> hdl/spg_top.sv
// Single-pin GPIO with debounce, edge flags and AHB-Lite registers
`timescale 1ns/1ps
module spg_top
    import spg_pkg::*;
#(
    parameter int unsigned FILTER_CYCLES = FILTER_CYCLE_COUNT
)
(
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic BIAS_ON,
    input wire logic PIN_IN,
    output logic PIN_OUT,
    output logic PIN_OE,
    output logic IRQ_LOW_OUT,
    output logic OSC_RUN
);
    logic [3:0] ctrl_r;
    logic [3:0] ctrl_nxt;
    logic [1:0] flag_r;
    logic [1:0] flag_nxt;
    logic [1:0] mask_r;
    logic [1:0] mask_nxt;
    logic wr_pend_r;
    logic wr_pend_nxt;
    logic [7:0] wr_addr_r;
    logic [7:0] wr_addr_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic pin_out_r;
    logic pin_out_nxt;
    logic pin_oe_r;
    logic pin_oe_nxt;
    logic irq_n_r;
    logic irq_n_nxt;
    logic osc_r;
    logic osc_nxt;
    logic prev_r;
    logic prev_nxt;
    logic ready_r;
    logic resp_r;
    logic sync_lvl;
    logic addr_take;
    logic out_en;
    logic irq_any;
    logic [1:0] edge_set;
    logic [1:0] flag_clr;

    spg_filt_if fif ();

    spg_sync u_sync
    (
        .clk(CLOCK),
        .rst_n(NRST),
        .d(PIN_IN),
        .q(sync_lvl)
    );

    spg_filter #(.CYCLES(FILTER_CYCLES)) u_filter
    (
        .clk(CLOCK),
        .rst_n(NRST),
        .f(fif.filt)
    );

    assign fif.raw = sync_lvl;
    assign fif.enable = ctrl_r[CTRL_FEN];
    assign fif.active = BIAS_ON;

    // Bus: zero wait states, read data fetched in the address phase
    assign addr_take = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);

    always_comb
    begin
        wr_pend_nxt = addr_take && HWRITE;
        wr_addr_nxt = addr_take ? HADDR[7:0] : wr_addr_r;
        rdata_nxt = 32'h0000_0000;
        if (addr_take && !HWRITE)
        begin
            case (HADDR[7:0])
                OFS_CTRL: rdata_nxt[3:0] = ctrl_r;
                OFS_STAT: rdata_nxt[2:0] = {osc_r, fif.level, sync_lvl};
                OFS_FLAG: rdata_nxt[1:0] = flag_r;
                OFS_MASK: rdata_nxt[1:0] = mask_r;
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CLOCK)
    begin
        if (!NRST)
        begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            rdata_r <= 32'h0000_0000;
            ready_r <= 1'b1;
            resp_r <= 1'b0;
        end
        else
        begin
            wr_pend_r <= wr_pend_nxt;
            wr_addr_r <= wr_addr_nxt;
            rdata_r <= rdata_nxt;
            ready_r <= 1'b1;
            // Every transfer is answered OKAY
            resp_r <= 1'b0;
        end
    end

    // Registers and sticky edge flags
    always_comb
    begin
        ctrl_nxt = ctrl_r;
        mask_nxt = mask_r;
        flag_clr = 2'h0;
        prev_nxt = fif.level;
        // Filter tracks the pin in standby, so waking gives no false edge
        edge_set[FLAG_RISE] = BIAS_ON && fif.level && !prev_r;
        edge_set[FLAG_FALL] = BIAS_ON && !fif.level && prev_r;
        if (wr_pend_r)
        begin
            case (wr_addr_r)
                OFS_CTRL: ctrl_nxt = HWDATA[3:0];
                OFS_FLAG: flag_clr = HWDATA[1:0];
                OFS_MASK: mask_nxt = HWDATA[1:0];
                default: ctrl_nxt = ctrl_r;
            endcase
        end
        // New edge wins over a clear in the same cycle
        flag_nxt = (flag_r & ~flag_clr) | edge_set;
    end

    always_ff @(posedge CLOCK)
    begin
        if (!NRST)
        begin
            ctrl_r <= CTRL_RESET;
            flag_r <= FLAG_RESET;
            mask_r <= MASK_RESET;
            prev_r <= 1'b0;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            flag_r <= flag_nxt;
            mask_r <= mask_nxt;
            prev_r <= prev_nxt;
        end
    end

    // Pin drivers, interrupt and oscillator status
    assign out_en = BIAS_ON && !ctrl_r[CTRL_DIR];
    assign irq_any = |(flag_r & ~mask_r);

    always_comb
    begin
        // Open-drain only ever enables the driver to pull low
        pin_oe_nxt = out_en && (ctrl_r[CTRL_DRV] || !ctrl_r[CTRL_VAL]);
        pin_out_nxt = out_en && ctrl_r[CTRL_DRV] && ctrl_r[CTRL_VAL];
        irq_n_nxt = !irq_any;
        osc_nxt = fif.osc_run;
    end

    always_ff @(posedge CLOCK)
    begin
        if (!NRST)
        begin
            pin_out_r <= 1'b0;
            pin_oe_r <= 1'b0;
            irq_n_r <= 1'b1;
            osc_r <= 1'b0;
        end
        else
        begin
            pin_out_r <= pin_out_nxt;
            pin_oe_r <= pin_oe_nxt;
            irq_n_r <= irq_n_nxt;
            osc_r <= osc_nxt;
        end
    end

    assign HRDATA = rdata_r;
    assign HREADYOUT = ready_r;
    assign HRESP = resp_r;
    assign PIN_OUT = pin_out_r;
    assign PIN_OE = pin_oe_r;
    assign IRQ_LOW_OUT = irq_n_r;
    assign OSC_RUN = osc_r;

    // Data-phase write strobe for one register
    function automatic logic wr_hit(logic pend, logic [7:0] a,
        logic [7:0] ofs);
        return pend && (a == ofs);
    endfunction

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!NRST);

    a_irq_level: assert property (1 |=> IRQ_LOW_OUT == !$past(irq_any))
        else $error("interrupt output disagrees with unmasked flags");
    a_mask_reset: assert property ($rose(NRST) |-> mask_r == 2'h3)
        else $error("masks not blocking after reset");
    a_push_pull: assert property (
        out_en && ctrl_r[CTRL_DRV] |=> PIN_OE && PIN_OUT == $past(ctrl_r[2]))
        else $error("push-pull output not driving written value");
    a_open_drain: assert property (
        !ctrl_r[CTRL_DRV] |=> !(PIN_OE && PIN_OUT))
        else $error("open-drain output drove high");
    a_input_only: assert property (
        ctrl_r[CTRL_DIR] |=> !PIN_OE)
        else $error("driver enabled in input mode");
    a_standby_off: assert property (
        !BIAS_ON |=> !PIN_OE && $past(edge_set) == 2'h0)
        else $error("pin active while bias off");
    a_level_read: assert property (
        addr_take && !HWRITE && HADDR[7:0] == OFS_STAT
        |=> HRDATA[0] == $past(sync_lvl))
        else $error("status does not show pin level");
    a_rise_flag: assert property (
        BIAS_ON && $rose(fif.level) |=> flag_r[FLAG_RISE])
        else $error("rising edge did not set rise flag");
    a_fall_flag: assert property (
        BIAS_ON && $fell(fif.level) |=> flag_r[FLAG_FALL])
        else $error("falling edge did not set fall flag");
    a_flag_sticky: assert property (
        flag_r[0] && !(wr_pend_r && wr_addr_r == OFS_FLAG && HWDATA[0])
        |=> flag_r[0])
        else $error("rise flag dropped without a clear");
    a_mask_block: assert property (
        flag_r == 2'h1 && mask_r[0] |=> IRQ_LOW_OUT)
        else $error("masked flag asserted interrupt");

    // Flag clears, register writes and standby behaviour
    a_rise_clear: assert property (
        wr_hit(wr_pend_r, wr_addr_r, OFS_FLAG) && HWDATA[FLAG_RISE]
        && !edge_set[FLAG_RISE] |=> !flag_r[FLAG_RISE])
        else $error("rise flag not cleared by write of one");
    a_fall_clear: assert property (
        wr_hit(wr_pend_r, wr_addr_r, OFS_FLAG) && HWDATA[FLAG_FALL]
        && !edge_set[FLAG_FALL] |=> !flag_r[FLAG_FALL])
        else $error("fall flag not cleared by write of one");
    // A same-cycle edge must survive the clear
    a_set_wins: assert property (
        edge_set != 2'h0
        |=> (flag_r & $past(edge_set)) == $past(edge_set))
        else $error("edge lost against a clear in the same cycle");
    a_fall_sticky: assert property (
        flag_r[FLAG_FALL]
        && !(wr_hit(wr_pend_r, wr_addr_r, OFS_FLAG) && HWDATA[FLAG_FALL])
        |=> flag_r[FLAG_FALL])
        else $error("fall flag dropped without a clear");
    a_ctrl_write: assert property (
        wr_hit(wr_pend_r, wr_addr_r, OFS_CTRL)
        |=> ctrl_r == $past(HWDATA[3:0]))
        else $error("control write not taken");
    a_mask_write: assert property (
        wr_hit(wr_pend_r, wr_addr_r, OFS_MASK)
        |=> mask_r == $past(HWDATA[1:0]))
        else $error("mask write not taken");
    a_od_release: assert property (
        out_en && !ctrl_r[CTRL_DRV] && ctrl_r[CTRL_VAL] |=> !PIN_OE)
        else $error("open-drain high did not release the pin");
    a_irq_unmasked: assert property (
        (flag_r & ~mask_r) != 2'h0 |=> !IRQ_LOW_OUT)
        else $error("unmasked flag did not assert interrupt");
    a_bypass_level: assert property (
        BIAS_ON && !ctrl_r[CTRL_FEN] |=> fif.level == $past(sync_lvl))
        else $error("filter off but level did not follow pin");
    a_osc_filter_off: assert property (
        !ctrl_r[CTRL_FEN] |=> !OSC_RUN)
        else $error("oscillator running with filter off");
    // Standby sets no new flags while the filter keeps tracking
    a_osc_standby: assert property (
        !BIAS_ON |=> !OSC_RUN)
        else $error("oscillator running in standby");
    a_standby_flags: assert property (
        !BIAS_ON |=> (flag_r & ~$past(flag_r)) == 2'h0)
        else $error("flag set while in standby");

    c_rise_irq: cover property (flag_r[0] && !mask_r[0] ##1 !IRQ_LOW_OUT);
    c_fall_flag: cover property ($rose(flag_r[FLAG_FALL]));
    c_od_low: cover property (PIN_OE && !PIN_OUT && !ctrl_r[CTRL_DRV]);
    c_standby_wake: cover property (!BIAS_ON ##1 BIAS_ON);
endmodule

// >>> verification/spg_pin_model.sv
// Outside circuit on the pin: optional driver plus pull-up resistor
`timescale 1ns/1ps
module spg_pin_model
(
    input wire logic pin_out,
    input wire logic pin_oe,
    input wire logic ext_en,
    input wire logic ext_val,
    output logic pin_in
);
    // Contention resolves low, as a wired-AND line would
    always_comb
    begin
        if (pin_oe && ext_en)
            pin_in = pin_out & ext_val;
        else if (pin_oe)
            pin_in = pin_out;
        else if (ext_en)
            pin_in = ext_val;
        else
            pin_in = 1'b1;
    end
endmodule

// >>> verification/spg_top_tb.sv
// Self-checking bench for the single-pin GPIO block
`timescale 1ns/1ps
module spg_top_tb
    import spg_pkg::*;
;
    localparam int FC = 20;
    localparam int P_OE = 0;
    localparam int P_OUT = 1;
    localparam int P_IRQ = 2;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic bias_on = 1'b1;
    logic ext_en = 1'b1;
    logic ext_val = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hrdata, q, rnd;
    logic hreadyout, hresp, pin_in, pin_out, pin_oe, irq_n, osc_run;
    logic lvl, n;
    logic [1:0] fl, mk, cl;
    int n_fail = 0;
    int checked = 0;
    int cyc = 0;
    int seed = 9147;
    spg_top #(.FILTER_CYCLES(FC)) DUT (.CLOCK(clock), .NRST(nrst),
        .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
        .BIAS_ON(bias_on), .PIN_IN(pin_in), .PIN_OUT(pin_out),
        .PIN_OE(pin_oe), .IRQ_LOW_OUT(irq_n), .OSC_RUN(osc_run));
    spg_pin_model PIN (.pin_out(pin_out), .pin_oe(pin_oe),
        .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
    initial
    begin
        forever #5 clock = ~clock;
    end
    task report_and_stop();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Guards against a hung handshake
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_fail = n_fail + 1;
            report_and_stop();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked = checked + 1;
        if (got !== exp)
        begin
            n_fail = n_fail + 1;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Values read at the falling edge are those the next rise samples
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic r;
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        do begin @(negedge clock); r = hreadyout; @(posedge clock); end
        while (r !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do begin @(negedge clock); r = hreadyout; q = hrdata;
            @(posedge clock); end
        while (r !== 1'b1);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(q, exp);
        chk({31'h0000_0000, hresp}, 32'h0000_0000);
    endtask
    // Pin picked by selector so it is read at the falling edge
    task pin_chk(input int sel, input logic exp);
        logic got;
        @(negedge clock);
        case (sel)
            P_OE: got = pin_oe;
            P_OUT: got = pin_out;
            P_IRQ: got = irq_n;
            default: got = osc_run;
        endcase
        chk({31'h0000_0000, got}, {31'h0000_0000, exp});
        @(posedge clock);
    endtask
    function automatic logic [1:0] edge_flags(logic [1:0] f, logic o,
        logic nw);
        return f | {o & ~nw, ~o & nw};
    endfunction
    function automatic logic irq_exp(logic [1:0] f, logic [1:0] m);
        return ~|(f & ~m);
    endfunction
    initial
    begin
        repeat (4) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        rd(OFS_CTRL, {28'h000_0000, CTRL_RESET});
        rd(OFS_FLAG, {30'h0000_0000, FLAG_RESET});
        rd(OFS_MASK, {30'h0000_0000, MASK_RESET});
        rd(8'h10, 32'h0000_0000);
        pin_chk(P_OE, 1'b0);
        ext_en <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            wr(OFS_CTRL, {28'h000_0000, 1'b0, i[1], i[0], 1'b0});
            repeat (8) @(posedge clock);
            pin_chk(P_OE, i[0] | ~i[1]);
            if (i[0] || !i[1])
                pin_chk(P_OUT, i[1]);
            rd(OFS_STAT, {29'h0000_0000, 1'b0, i[1], i[1]});
        end
        // Pull-up blip before the first write gives a rise and a fall
        rd(OFS_FLAG, 32'h0000_0003);
        pin_chk(P_IRQ, 1'b1);
        ext_val <= 1'b1;
        ext_en <= 1'b1;
        wr(OFS_CTRL, 32'h0000_0001);
        repeat (8) @(posedge clock);
        pin_chk(P_OE, 1'b0);
        wr(OFS_FLAG, 32'h0000_0003);
        lvl = 1'b1;
        fl = 2'h0;
        for (int i = 0; i < 24; i++)
        begin
            rnd = $random(seed);
            mk = rnd[1:0];
            n = rnd[4];
            cl = rnd[9:8];
            wr(OFS_MASK, {30'h0000_0000, mk});
            ext_val <= n;
            repeat (10) @(posedge clock);
            fl = edge_flags(fl, lvl, n);
            lvl = n;
            rd(OFS_FLAG, {30'h0000_0000, fl});
            pin_chk(P_IRQ, irq_exp(fl, mk));
            wr(OFS_FLAG, {30'h0000_0000, cl});
            fl = fl & ~cl;
        end
        repeat (3) @(posedge clock);
        pin_chk(P_IRQ, irq_exp(fl, mk));
        wr(OFS_MASK, 32'h0000_0000);
        wr(OFS_FLAG, 32'h0000_0003);
        fl = 2'h0;
        wr(OFS_CTRL, 32'h0000_0009);
        repeat (5) @(posedge clock);
        // Bounce shorter than the filter time must vanish
        ext_val <= ~lvl;
        repeat (10) @(posedge clock);
        pin_chk(3, 1'b1);
        ext_val <= lvl;
        repeat (15) @(posedge clock);
        rd(OFS_FLAG, 32'h0000_0000);
        pin_chk(3, 1'b0);
        ext_val <= ~lvl;
        repeat (FC - 5) @(posedge clock);
        rd(OFS_FLAG, 32'h0000_0000);
        repeat (15) @(posedge clock);
        fl = edge_flags(fl, lvl, ~lvl);
        rd(OFS_FLAG, {30'h0000_0000, fl});
        rd(OFS_STAT, {29'h0000_0000, 1'b0, ~lvl, ~lvl});
        pin_chk(P_IRQ, 1'b0);
        lvl = ~lvl;
        wr(OFS_FLAG, 32'h0000_0003);
        bias_on <= 1'b0;
        wr(OFS_CTRL, 32'h0000_0006);
        repeat (4) @(posedge clock);
        pin_chk(P_OE, 1'b0);
        wr(OFS_CTRL, 32'h0000_0001);
        ext_val <= ~lvl;
        repeat (10) @(posedge clock);
        rd(OFS_FLAG, 32'h0000_0000);
        pin_chk(P_IRQ, 1'b1);
        bias_on <= 1'b1;
        report_and_stop();
    end
endmodule
